// >>> core/dlbe_pkg.sv
/*
 * Constants, field positions and types for the decorated load bit engine.
 * Assumes an AHB-Lite style core port and a peripheral slave port on one clock.
 */
package dlbe_pkg;

   typedef logic [31:0] dlbe_word_t;

   // Peripheral space and the stripped base for decorated offsets.
   localparam dlbe_word_t  PERIPH_BASE   = 32'h4000_0000;
   localparam logic [2:0]  PERIPH_TAG    = 3'h2;
   localparam int          TAG_HI        = 31;
   localparam int          TAG_LO        = 29;
   localparam int          OP_HI         = 28;
   localparam int          OP_LO         = 26;
   localparam logic [2:0]  OP_NONE       = 3'h0;
   localparam logic [2:0]  OP_SET_BIT    = 3'h3;
   localparam int          XTR_FLAG      = 28;

   // Load-and-set-bit fields.
   localparam int          SET_B_HI      = 25;
   localparam int          SET_B_LO      = 21;
   localparam int          SET_OFS_HI    = 19;

   // Unsigned field extract fields.
   localparam int          XTR_B_HI      = 27;
   localparam int          XTR_B_LO      = 23;
   localparam int          XTR_W_HI      = 22;
   localparam int          XTR_W_LO      = 19;
   localparam int          XTR_OFS_HI    = 18;

   // Undecorated windows: normal slots and the standard GPIO page.
   localparam int          PASS_HI       = 28;
   localparam int          PASS_LO       = 19;
   localparam int          GPIO_HI       = 28;
   localparam int          GPIO_LO       = 12;
   localparam logic [16:0] GPIO_STD_PAGE = 17'h000FF;

   // Bus encodings.
   localparam logic [1:0]  HT_IDLE       = 2'h0;
   localparam logic [2:0]  HSIZE_B       = 3'h0;
   localparam logic [2:0]  HSIZE_H       = 3'h1;
   localparam logic [2:0]  HSIZE_W       = 3'h2;

   // Bit index and container masks per transfer size.
   localparam logic [4:0]  BMASK_B       = 5'h07;
   localparam logic [4:0]  BMASK_H       = 5'h0F;
   localparam logic [4:0]  BMASK_W       = 5'h1F;
   localparam dlbe_word_t  CMASK_B       = 32'h0000_00FF;
   localparam dlbe_word_t  CMASK_H       = 32'h0000_FFFF;
   localparam dlbe_word_t  CMASK_W       = 32'hFFFF_FFFF;

   typedef enum logic [2:0] {
      st_open, st_set_rd, st_set_ret, st_xtr_rd, st_xtr_ret, st_err_beg, st_err_end
   } dlbe_state_e;

endpackage

// >>> core/dlbe_field.sv
/*
 * Combinational bit and field selector used by the bit engine.
 * Assumes bit position already masked to the container and lane from the size.
 */
`timescale 1ns/1ps
module dlbe_field (
   input  wire dlbe_pkg::dlbe_word_t rdata,
   input  wire logic [1:0]           lane,
   input  wire logic [2:0]           size,
   input  wire logic [4:0]           lsb,
   input  wire logic [3:0]           wcode,
   output logic                      sel_bit,
   output dlbe_pkg::dlbe_word_t      set_data,
   output dlbe_pkg::dlbe_word_t      field
);
   import dlbe_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Container view: the addressed lane moved down and cut to the size.
   wire logic [4:0]  lane_sh  = {lane, 3'h0};
   wire dlbe_word_t  cmask    = (size == HSIZE_B) ? CMASK_B :
                                (size == HSIZE_H) ? CMASK_H : CMASK_W;
   wire dlbe_word_t  cont     = (rdata >> lane_sh) & cmask;
   wire logic [4:0]  abs_pos  = lane_sh + lsb;

   // Field mask; the container mask cuts any part beyond the top.
   wire logic [32:0] wide_one = 33'h1_0000_0000 >> (5'h1F - {1'b0, wcode});
   wire dlbe_word_t  wmask    = wide_one[31:0] - 32'h1;
   wire dlbe_word_t  fmask    = (wmask << lsb) & cmask;

   // Outputs for the set and extract paths.
   assign sel_bit  = rdata[abs_pos];                              // R1
   assign set_data = rdata | (32'h1 << abs_pos);                  // R6
   assign field    = cont & fmask;                                // R12
endmodule

// >>> core/dlbe_core.sv
/*
 * Decorated load bit engine between a core bus master and peripheral slaves.
 * Assumes an AHB-Lite master port and one slave port, both on clock/rst_n;
 * the slave side answers an idle cycle with ready high and no error.
 */
// Notes on behaviour
// [R1] Set-bit load returns the addressed bit and leaves it one in memory, atomically.
// [R2] The returned bit sits at bit zero; every higher bit reads zero.
// [R3] Set-bit container is byte, halfword or word, from the read size.
// [R4] Set-bit decode: bits 30:29 = 10, 28:26 = 011; bit 25:21, offset 19:0.
// [R5] Set-bit issues the stripped read, then reissues captured address as a write.
// [R6] First data phase reads, forms mask, picks bit, registers data ORed with mask.
// [R7] Third cycle returns the bit while the slave receives the modified data.
// [R8] Field extract reads lsb and width code plus one, two cycles, no write.
// [R9] Word field extract supports at most sixteen bits; smaller containers follow size.
// [R10] Extract decode: 30:29 = 10, bit 28 one; lsb 27:23, width 22:19, offset 18:0.
// [R11] For extract, address bit 19 is the width low bit, not an offset bit.
// [R12] A field running past the container keeps only the bits that fit.
// [R13] Extract second address phase is idle; first data phase masks and registers.
// [R14] Extract third cycle shifts the field down to bit zero, zero-extended.
// [R15] The normal peripheral range passes through undecorated.
// [R16] Both illegal ranges are aborted with an error response.
// [R17] GPIO answers at the standard base and in its alternate slot.
// [R18] Decorated set-bit range reaches peripherals and GPIO through either base.
// [R19] Extract reaches GPIO only through the alternate base; software must respect this.
// [R20] Peripheral space is 129 slots of 4 KB: 128 normal plus GPIO.
// [R21] Software extracts a single bit with width code zero.
// [R22] Slave wait states reach the core unchanged, cycle for cycle.
// [R23] The core is held one wait state in the first decorated data phase.
// [R24] Plain accesses pass with unchanged address, size, data and no added waits.
`timescale 1ns/1ps
module dlbe_core (
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire dlbe_pkg::dlbe_word_t m_haddr,
   input  wire logic [1:0]           m_htrans,
   input  wire logic                 m_hwrite,
   input  wire logic [2:0]           m_hsize,
   input  wire logic [3:0]           m_hprot,
   input  wire dlbe_pkg::dlbe_word_t m_hwdata,
   output logic                      m_hready_out,
   output dlbe_pkg::dlbe_word_t      m_hrdata,
   output logic                      m_hresp,
   output dlbe_pkg::dlbe_word_t      s_haddr,
   output logic [1:0]                s_htrans,
   output logic                      s_hwrite,
   output logic [2:0]                s_hsize,
   output logic [3:0]                s_hprot,
   output dlbe_pkg::dlbe_word_t      s_hwdata,
   input  wire dlbe_pkg::dlbe_word_t s_hrdata,
   input  wire logic                 s_hready,
   input  wire logic                 s_hresp
);
   import dlbe_pkg::*;

   dlbe_state_e state_r;
   dlbe_state_e state_nxt;
   dlbe_word_t  addr_r;
   logic [2:0]  size_r;
   logic [3:0]  prot_r;
   logic [4:0]  lsb_r;
   logic [3:0]  wcode_r;
   logic [1:0]  lane_r;
   dlbe_word_t  wdata_r;
   logic        bit_r;
   dlbe_word_t  field_r;
   logic        sel_bit;
   dlbe_word_t  set_data;
   dlbe_word_t  field;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode of the core's current address phase.
   wire logic       open_st  = (state_r == st_open) || (state_r == st_set_ret) ||
                               (state_r == st_xtr_ret) || (state_r == st_err_end);
   wire logic       acc      = open_st && s_hready && m_htrans[1];
   wire logic       in_per   = (m_haddr[TAG_HI:TAG_LO] == PERIPH_TAG);
   wire logic [2:0] op_code  = m_haddr[OP_HI:OP_LO];
   wire logic       is_dec   = in_per && (op_code != OP_NONE);
   wire logic       is_set   = in_per && (op_code == OP_SET_BIT);            // R4 R18
   wire logic       is_xtr   = in_per && m_haddr[XTR_FLAG];                  // R10 R19
   wire logic       size_ok  = (m_hsize <= HSIZE_W);                         // R3
   wire logic       set_ok   = is_set && !m_hwrite && size_ok;
   wire logic       xtr_ok   = is_xtr && !m_hwrite && size_ok;

   // Undecorated: 128 normal slots plus the standard GPIO page.
   wire logic       slot_ok  = (m_haddr[PASS_HI:PASS_LO] == '0);             // R15 R20
   wire logic       gpio_ok  = (m_haddr[GPIO_HI:GPIO_LO] == GPIO_STD_PAGE);  // R17
   wire logic       bad      = in_per && (is_dec ? !(set_ok || xtr_ok)
                                                 : !(slot_ok || gpio_ok));   // R16

   // Decorations removed; extract keeps bit 19 as width, not offset.
   wire dlbe_word_t set_addr = {PERIPH_BASE[31:SET_OFS_HI+1], m_haddr[SET_OFS_HI:0]};
   wire dlbe_word_t xtr_addr = {PERIPH_BASE[31:XTR_OFS_HI+1], m_haddr[XTR_OFS_HI:0]}; // R11
   wire dlbe_word_t fwd_addr = set_ok ? set_addr : xtr_ok ? xtr_addr : m_haddr;

   // Bit position is cut to the container; lane follows the low address.
   wire logic [4:0] b_mask   = (m_hsize == HSIZE_B) ? BMASK_B :
                               (m_hsize == HSIZE_H) ? BMASK_H : BMASK_W;     // R3 R9
   wire logic [4:0] lsb_in   = (xtr_ok ? m_haddr[XTR_B_HI:XTR_B_LO]
                                       : m_haddr[SET_B_HI:SET_B_LO]) & b_mask;
   wire logic [1:0] lane_in  = (m_hsize == HSIZE_B) ? m_haddr[1:0] :
                               (m_hsize == HSIZE_H) ? {m_haddr[1], 1'b0} : 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Selector working on live slave read data with the captured operands.
   dlbe_field u_field (
      .rdata    (s_hrdata),
      .lane     (lane_r),
      .size     (size_r),
      .lsb      (lsb_r),
      .wcode    (wcode_r),
      .sel_bit  (sel_bit),
      .set_data (set_data),
      .field    (field)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer; acceptance waits on slave ready so slave stalls pass through.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_set_rd: begin
            if (s_hready) state_nxt = st_set_ret;                             // R5 R22
         end
         st_xtr_rd: begin
            if (s_hready) state_nxt = st_xtr_ret;                             // R22
         end
         st_err_beg: begin
            state_nxt = st_err_end;                                           // R16
         end
         default: begin
            if (s_hready) begin
               if (acc && set_ok) state_nxt = st_set_rd;
               else if (acc && xtr_ok) state_nxt = st_xtr_rd;
               else if (acc && bad) state_nxt = st_err_beg;
               else state_nxt = st_open;
            end
         end
      endcase
   end

   // State register.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) state_r <= st_open;
      else state_r <= state_nxt;
   end

   // Capture of address and attributes in the first address phase.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         addr_r  <= '0;
         size_r  <= HSIZE_B;
         prot_r  <= '0;
         lsb_r   <= '0;
         wcode_r <= '0;
         lane_r  <= '0;
      end else if (acc && (set_ok || xtr_ok)) begin
         addr_r  <= fwd_addr;                                                 // R5
         size_r  <= m_hsize;
         prot_r  <= m_hprot;
         lsb_r   <= lsb_in;
         wcode_r <= m_haddr[XTR_W_HI:XTR_W_LO];                               // R11
         lane_r  <= lane_in;
      end
   end

   // First data phase results are held for the returning cycle.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wdata_r <= '0;
         bit_r   <= 1'b0;
         field_r <= '0;
      end else if (s_hready && (state_r == st_set_rd)) begin
         wdata_r <= set_data;                                                 // R6
         bit_r   <= sel_bit;                                                  // R1
      end else if (s_hready && (state_r == st_xtr_rd)) begin
         field_r <= field;                                                    // R13
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Slave side: forwarded address phase, recirculated write, or idle.
   // These stay combinational so plain transfers add no wait cycle.
   wire logic  fwd_idle = bad || !m_htrans[1];
   wire logic  set_wr   = (state_r == st_set_rd);

   assign s_haddr  = set_wr ? addr_r : fwd_addr;                              // R5 R24
   assign s_htrans = set_wr ? 2'h2 : (open_st && !fwd_idle) ? m_htrans : HT_IDLE; // R13
   assign s_hwrite = set_wr ? 1'b1 : (open_st && m_hwrite);                   // R8
   assign s_hsize  = set_wr ? size_r : m_hsize;
   assign s_hprot  = set_wr ? prot_r : m_hprot;
   assign s_hwdata = (state_r == st_set_ret) ? wdata_r : m_hwdata;            // R7

   // Core side: stall in the first decorated data phase, error for two cycles.
   wire dlbe_word_t xtr_out = field_r >> lsb_r;                               // R14
   assign m_hready_out = open_st && s_hready;                                 // R23 R22
   assign m_hresp      = (state_r == st_err_beg) || (state_r == st_err_end) ||
                         ((state_r == st_open) && s_hresp);
   assign m_hrdata     = (state_r == st_set_ret) ? {31'h0, bit_r} :           // R2 R7
                         (state_r == st_xtr_ret) ? xtr_out : s_hrdata;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer and the data paths.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   wire logic [4:0] abs_pos = {lane_r, 3'h0} + lsb_r;
   wire logic [5:0] w_len   = {2'h0, wcode_r} + 6'h1;
   wire logic       dec_rd  = (state_r == st_set_rd) || (state_r == st_xtr_rd);

   a_set_decode: assert property (acc && set_ok |->                           // R4
      s_haddr == {PERIPH_BASE[31:20], m_haddr[19:0]} && !s_hwrite)
      else $error("set-bit read address not stripped");

   a_set_rewrite: assert property (acc && set_ok |=>                          // R5
      (s_htrans == 2'h2 && s_hwrite && s_haddr == $past(s_haddr)))
      else $error("set-bit write not reissued at captured address");

   a_set_data: assert property ((state_r == st_set_rd) && s_hready |=>        // R6
      s_hwdata == ($past(s_hrdata) | (32'h1 << abs_pos)))
      else $error("set-bit write data wrong");

   a_set_return: assert property ((state_r == st_set_rd) && s_hready |=>      // R2
      m_hrdata == (($past(s_hrdata) >> abs_pos) & 32'h1))
      else $error("set-bit return value wrong");

   // Checked per state, so slave waits and a back-to-back write cannot trip them.
   a_xtr_idle: assert property ((state_r == st_xtr_rd) |->                   // R13
      (s_htrans == HT_IDLE) && !m_hready_out)
      else $error("extract not idle on slave side");

   a_xtr_no_wr: assert property ((state_r == st_xtr_rd) |->                  // R8
      !(s_hwrite && s_htrans[1]))
      else $error("extract issued a write");

   a_xtr_align: assert property ((state_r == st_xtr_rd) && s_hready |=>       // R14
      (m_hrdata >> w_len) == 32'h0 &&
      m_hrdata[0] == $past(s_hrdata[abs_pos]))
      else $error("extract result not right aligned");

   a_err_pair: assert property (acc && bad |=>                                // R16
      (m_hresp && !m_hready_out && s_htrans == HT_IDLE) ##1 (m_hresp && m_hready_out))
      else $error("illegal access not error terminated");

   // Slave waits stretch the stall, so the check starts at the completing read.
   a_dec_stall: assert property (dec_rd && s_hready |->                      // R23
      !m_hready_out ##1 ((state_r == st_set_ret) || (state_r == st_xtr_ret)))
      else $error("decorated load not held one wait state");

   a_pass_ready: assert property ((state_r == st_open) |->                    // R22
      (m_hready_out == s_hready) && (m_hrdata == s_hrdata))
      else $error("plain transfer ready or data altered");

   a_pass_addr: assert property (acc && in_per && !is_dec && !bad |->         // R24
      (s_haddr == m_haddr) && (s_hsize == m_hsize) && (s_htrans == m_htrans))
      else $error("plain transfer address changed");

   c_set_done: cover property (acc && set_ok ##1 s_hready ##1 m_hready_out);
   c_xtr_done: cover property (acc && xtr_ok ##2 (state_r == st_xtr_ret));
   c_err_done: cover property (acc && bad ##2 m_hresp && m_hready_out);
   c_slv_wait: cover property ((state_r == st_set_rd) && !s_hready);
endmodule

// >>> verif/dlbe_slave_model.sv
/*
 * Peripheral slave model: a small word memory behind an AHB-Lite slave port.
 * Assumes the engine clock and reset; the wait count applies to every non-idle data phase.
 */
`timescale 1ns/1ps
module dlbe_slave_model (
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire dlbe_pkg::dlbe_word_t s_haddr,
   input  wire logic [1:0]           s_htrans,
   input  wire logic                 s_hwrite,
   input  wire logic [2:0]           s_hsize,
   input  wire dlbe_pkg::dlbe_word_t s_hwdata,
   input  wire logic [3:0]           waits,
   output dlbe_pkg::dlbe_word_t      s_hrdata,
   output logic                      s_hready,
   output logic                      s_hresp,
   output logic [15:0]               wr_count,
   output logic [15:0]               acc_count
);
   import dlbe_pkg::*;
   dlbe_word_t mem [256];
   logic       dp_r, wr_r, pat_r;
   logic [7:0] idx_r;
   logic [3:0] be_r, wcnt_r, be_nxt;
   ////////////////////////////////////////////////////////////////////////////////
   // Lanes from size; the memory aliases on address bits 9:2, so both GPIO bases meet.
   assign be_nxt = (s_hsize == HSIZE_B) ? (4'h1 << s_haddr[1:0]) :
                   (s_hsize == HSIZE_H) ? (4'h3 << {s_haddr[1], 1'b0}) : 4'hF;
   // Outside a finishing read the data lines toggle, so stale data can never pass.
   assign s_hready = !dp_r || (wcnt_r == 4'h0);
   assign s_hresp  = 1'b0;
   assign s_hrdata = (dp_r && !wr_r && s_hready) ? mem[idx_r] :
                     (pat_r ? 32'h5AC3_3CA5 : 32'hA53C_C35A);
   ////////////////////////////////////////////////////////////////////////////////
   // Data phase pipeline; a write lands when its data phase completes.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {dp_r, wr_r, pat_r, idx_r, be_r, wcnt_r} <= '0;
         wr_count  <= 16'h0;
         acc_count <= 16'h0;
      end else begin
         pat_r <= !pat_r;
         if (s_hready) begin
            for (int i = 0; i < 4; i++) begin
               if (dp_r && wr_r && be_r[i]) mem[idx_r][8*i +: 8] <= s_hwdata[8*i +: 8];
            end
            if (dp_r && wr_r) wr_count <= wr_count + 16'h1;
            if (s_htrans[1]) acc_count <= acc_count + 16'h1;
            dp_r   <= s_htrans[1];
            wr_r   <= s_hwrite;
            idx_r  <= s_haddr[9:2];
            be_r   <= be_nxt;
            wcnt_r <= waits;
         end else begin
            wcnt_r <= wcnt_r - 4'h1;
         end
      end
   end
endmodule

// >>> verif/tb.sv
/*
 * Self-checking bench for the decorated load bit engine.
 * Assumes the slave model on the far side; the bench acts as the core bus master.
 */
`timescale 1ns/1ps
module tb;
   import dlbe_pkg::*;
   logic        clock, rst_n, m_hwrite, m_hready_out, m_hresp, s_hwrite, s_hready, s_hresp;
   logic [1:0]  m_htrans, s_htrans;
   logic [2:0]  m_hsize, s_hsize;
   logic [3:0]  s_hprot, waits, m_hprot, sp;
   logic [15:0] wr_count, acc_count, w0, a0;
   dlbe_word_t  m_haddr, m_hwdata, m_hrdata, s_haddr, s_hwdata, s_hrdata, rd, sa;
   logic        rsp;
   int          err_count, checks_done, ncyc;
   dlbe_core dut_u (.clock(clock), .rst_n(rst_n), .m_haddr(m_haddr), .m_htrans(m_htrans),
      .m_hwrite(m_hwrite), .m_hsize(m_hsize), .m_hprot(m_hprot), .m_hwdata(m_hwdata),
      .m_hready_out(m_hready_out), .m_hrdata(m_hrdata), .m_hresp(m_hresp),
      .s_haddr(s_haddr), .s_htrans(s_htrans), .s_hwrite(s_hwrite), .s_hsize(s_hsize),
      .s_hprot(s_hprot), .s_hwdata(s_hwdata), .s_hrdata(s_hrdata), .s_hready(s_hready),
      .s_hresp(s_hresp));
   dlbe_slave_model slave_u (.clock(clock), .rst_n(rst_n), .s_haddr(s_haddr),
      .s_htrans(s_htrans), .s_hwrite(s_hwrite), .s_hsize(s_hsize), .s_hwdata(s_hwdata),
      .waits(waits), .s_hrdata(s_hrdata), .s_hready(s_hready), .s_hresp(s_hresp),
      .wr_count(wr_count), .acc_count(acc_count));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 100 ns.
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Compare and count.
   task automatic check(input string what, input dlbe_word_t seen, input dlbe_word_t exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One transfer, entered at a falling edge; values are read just before each rising edge.
   task automatic xfer(input dlbe_word_t a, input logic w, input logic [2:0] sz,
                       input dlbe_word_t wd);
      logic rdy;
      int   n;
      m_haddr  = a;
      m_htrans = 2'h2;
      m_hwrite = w;
      m_hsize  = sz;
      n = 0;
      do begin
         #49 rdy = m_hready_out;
         sa = s_haddr;
         @(negedge clock);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) check("address handshake", 32'h0, 32'h1);
      m_htrans = HT_IDLE;
      m_hwdata = wd;
      // Protection bits flip in the data phase so a reissued write must use the captured ones.
      m_hprot  = ~m_hprot;
      ncyc = 0;
      do begin
         #49 rdy = m_hready_out;
         rd  = m_hrdata;
         rsp = m_hresp;
         if (ncyc == 0) sp = s_hprot;
         @(negedge clock);
         ncyc++;
      end while (rdy !== 1'b1 && ncyc < 50);
      m_hprot = ~m_hprot;
      if (rdy !== 1'b1) check("handshake", 32'h0, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Plain and GPIO traffic, with and without slave waits.
   task automatic t_plain();
      waits = 4'h0;
      xfer(32'h4000_0040, 1'b1, HSIZE_W, 32'h1357_9BDF);
      check("plain addr", sa, 32'h4000_0040);
      xfer(32'h4000_0040, 1'b0, HSIZE_W, 32'h0);
      check("plain read", rd, 32'h1357_9BDF);
      check("plain cycles", 32'(ncyc), 32'h1);
      xfer(32'h400F_F044, 1'b1, HSIZE_W, 32'h2468_ACE0);
      check("gpio addr", sa, 32'h400F_F044);
      xfer(32'h4000_F044, 1'b0, HSIZE_W, 32'h0);
      check("gpio alias", rd, 32'h2468_ACE0);
      waits = 4'h2;
      xfer(32'h4000_0040, 1'b0, HSIZE_W, 32'h0);
      check("plain waits", 32'(ncyc), 32'h3);
      waits = 4'h0;
      $display("test plain done");
   endtask
   // Set-bit loads in every container size; the second load sees the bit set.
   task automatic t_setbit();
      dlbe_word_t ofs[3] = '{32'h20, 32'h26, 32'h2B};
      logic [2:0] sz[3]  = '{HSIZE_W, HSIZE_H, HSIZE_B};
      int         b[3]   = '{5, 10, 7};
      int         wb[3]  = '{5, 26, 31};
      for (int i = 0; i < 3; i++) begin
         xfer(32'h4000_0000 | (ofs[i] & 32'hFC), 1'b1, HSIZE_W, 32'h5A5A_0F0F);
         w0 = wr_count;
         xfer(32'h4C00_0000 | (b[i] << 21) | ofs[i], 1'b0, sz[i], 32'h0);
         check("set old bit", rd, 32'h0);
         check("set cycles", 32'(ncyc), 32'h2);
         xfer(32'h4C00_0000 | (b[i] << 21) | ofs[i], 1'b0, sz[i], 32'h0);
         check("set new bit", rd, 32'h1);
         check("set writes", 32'(wr_count - w0), 32'h2);
         check("set prot", 32'(sp), 32'h3);
         xfer(32'h4000_0000 | (ofs[i] & 32'hFC), 1'b0, HSIZE_W, 32'h0);
         check("set memory", rd, 32'h5A5A_0F0F | (32'h1 << wb[i]));
      end
      waits = 4'h1;
      xfer(32'h4C00_0000 | (5 << 21) | 32'h20, 1'b0, HSIZE_W, 32'h0);
      check("set waits", 32'(ncyc), 32'h4);
      check("set held", rd, 32'h1);
      waits = 4'h0;
      $display("test setbit done");
   endtask
   // Field extracts: wide, sixteen-bit, clipped byte and single bit via the GPIO slot.
   task automatic t_extract();
      dlbe_word_t ofs[4] = '{32'h30, 32'h30, 32'h31, 32'hF032};
      logic [2:0] sz[4]  = '{HSIZE_W, HSIZE_W, HSIZE_B, HSIZE_H};
      dlbe_word_t cm[4]  = '{CMASK_W, CMASK_W, CMASK_B, CMASK_H};
      int         b[4]   = '{4, 8, 6, 13};
      int         w[4]   = '{7, 15, 3, 0};
      dlbe_word_t c;
      xfer(32'h4000_0030, 1'b1, HSIZE_W, 32'h89AB_CDEF);
      w0 = wr_count;
      for (int i = 0; i < 4; i++) begin
         c = (32'h89AB_CDEF >> (8 * ofs[i][1:0])) & cm[i];
         xfer(32'h5000_0000 | (b[i] << 23) | (w[i] << 19) | ofs[i], 1'b0, sz[i], 32'h0);
         check("field", rd, (c >> b[i]) & ((32'h1 << (w[i] + 1)) - 1));
         check("field cycles", 32'(ncyc), 32'h2);
      end
      xfer(32'h5000_0030, 1'b0, HSIZE_W, 32'h0);
      check("single bit", rd, 32'h1);
      waits = 4'h2;
      xfer(32'h5000_0000 | (4 << 23) | (7 << 19) | 32'h30, 1'b0, HSIZE_W, 32'h0);
      check("field waits", 32'(ncyc), 32'h4);
      check("field value", rd, 32'h0000_00DE);
      check("field no write", 32'(wr_count - w0), 32'h0);
      waits = 4'h0;
      $display("test extract done");
   endtask
   // Illegal ranges at their edges and refused decorated accesses end in error off the slave.
   task automatic t_illegal();
      dlbe_word_t ad[6] = '{32'h4008_0000, 32'h400F_EFFC, 32'h4010_0000, 32'h43FF_FFFC,
                            32'h4400_0020, 32'h5000_0030};
      for (int i = 0; i < 6; i++) begin
         a0 = acc_count;
         xfer(ad[i], i[0], HSIZE_W, 32'hFFFF_FFFF);
         check("error resp", 32'(rsp), 32'h1);
         check("no access", 32'(acc_count - a0), 32'h0);
      end
      $display("test illegal done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // The only place the run ends.
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the hundred or so cycles the tests need.
   initial begin
      #(100 * 5000);
      err_count++;
      conclude();
   end
   // Main sequence.
   initial begin
      {rst_n, m_hwrite, m_haddr, m_hwdata, m_htrans, waits} = '0;
      m_hsize = HSIZE_W;
      m_hprot = 4'h3;
      err_count = 0;
      checks_done = 0;
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      t_plain();
      t_setbit();
      t_extract();
      t_illegal();
      conclude();
   end
endmodule
